// ===== rtl/rnseq_pkg.sv
// Purpose: Shared constants for the converter-four enable sequencer
// Assumes: 125 MHz system clock, byte-wide register port
// Notes:   Reset values are a local choice; delays are in whole milliseconds
`default_nettype none
package rnseq_pkg;
    // Register offsets
    localparam logic [7:0] OFF_GOOD_MASK_A    = 8'h10;
    localparam logic [7:0] OFF_SOURCE_MASK_B  = 8'h11;
    localparam logic [7:0] OFF_EDGE_DELAYS    = 8'h12;
    // Values after reset
    localparam logic [7:0] RST_GOOD_MASK_A    = 8'h00;
    localparam logic [7:0] RST_SOURCE_MASK_B  = 8'h00;
    localparam logic [7:0] RST_EDGE_DELAYS    = 8'h00;
    // Field positions
    localparam int SEL_LSB                    = 2;
    localparam int RISE_LSB                   = 0;
    localparam int FALL_LSB                   = 3;
    localparam int RSV_B_LSB                  = 5;
    // Enable source codes
    localparam logic [2:0] SRC_PIN_ONE        = 3'h0;
    localparam logic [2:0] SRC_PIN_TWO        = 3'h1;
    localparam logic [2:0] SRC_PIN_FIVE       = 3'h2;
    localparam logic [2:0] SRC_PIN_FOUR       = 3'h3;
    localparam logic [2:0] SRC_PIN_THREE      = 3'h4;
    localparam logic [2:0] SRC_PINS_3_AND_4   = 3'h5;
    localparam logic [2:0] SRC_PIN_SIX        = 3'h6;
    localparam logic [2:0] SRC_ALWAYS_ON      = 3'h7;
    // Timebase: one millisecond tick
    localparam int CLK_PERIOD_NS              = 8;
    localparam int TICK_PERIOD_NS             = 1000000;
    localparam int TICK_CYCLES                = TICK_PERIOD_NS / CLK_PERIOD_NS;
    // Delay table in milliseconds
    localparam logic [6:0] DLY_MS_0           = 7'h00;
    localparam logic [6:0] DLY_MS_1           = 7'h02;
    localparam logic [6:0] DLY_MS_2           = 7'h04;
    localparam logic [6:0] DLY_MS_3           = 7'h08;
    localparam logic [6:0] DLY_MS_4           = 7'h10;
    localparam logic [6:0] DLY_MS_5           = 7'h18;
    localparam logic [6:0] DLY_MS_6_DEFAULT   = 7'h20;
    localparam logic [6:0] DLY_MS_7           = 7'h40;
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        RN_OFF       = 4'h1,
        RN_RISE_WAIT = 4'h2,
        RN_ON        = 4'h4,
        RN_FALL_WAIT = 4'h8
    } rnseq_state_t;
endpackage
`default_nettype wire

// ===== rtl/rnseq_top.sv
// Purpose: Enable qualification and edge delay for converter four
// Assumes: Control pins and power-good flags are asynchronous
// Notes:   Divider restarts on each delay so counts are exact to a tick
//
// How it works
// - Mask bit 0 requires that rail good
// - Mask bit 1 ignores that rail good
// - Register A bits 7..0 map eight rails
// - Register B bits 1,0 mask two rails
// - Bits 4:2 select the enable pin source
// - Code 111 forces enable source high
// - Rising edge delayed per bits 2:0
// - Falling edge delayed per bits 5:3
// - Millisecond timebase within ten percent
`timescale 1ns/10ps
`default_nettype none
module rnseq_top
    import rnseq_pkg::*;
#(
    parameter int         TICK_LEN       = TICK_CYCLES,      // Cycles per ms tick
    parameter logic [6:0] DELAY_CODE6_MS = DLY_MS_6_DEFAULT  // Delay for code 110
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RSTN,
    input  wire logic [5:0] CTL_PIN,      // Control pins one..six
    input  wire logic [9:0] RAIL_GOOD,    // Power-good flags of other rails
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WE,
    output logic      [7:0] REG_RDATA,
    output logic            RAIL_ENABLE
);

    // Synchroniser stages
    logic [5:0]   ctl_s1;                 // First stage, pins
    logic [5:0]   ctl_s2;                 // Second stage, pins
    logic [9:0]   pg_s1;                  // First stage, good flags
    logic [9:0]   pg_s2;                  // Second stage, good flags
    // Registers and their next values
    logic [7:0]   mask_a;                 // Good masks, eight rails
    logic [7:0]   src_b;                  // Source select and two masks
    logic [7:0]   delays;                 // Edge delay codes
    logic [7:0]   next_mask_a;
    logic [7:0]   next_src_b;
    logic [7:0]   next_delays;
    logic [7:0]   next_rdata;
    // Sequencer state
    rnseq_state_t state;
    rnseq_state_t next_state;
    logic [31:0]  div;                    // Tick divider
    logic [31:0]  next_div;
    logic [6:0]   ms_cnt;                 // Elapsed ms in a delay
    logic [6:0]   next_ms_cnt;
    logic         next_enable;
    // Decoded terms
    logic         tick;                   // One-cycle ms pulse
    logic         src_en;                 // Selected pin level
    logic         req;                    // Qualified enable request
    logic [9:0]   mask;                   // All ten mask bits
    logic [6:0]   rise_ms;
    logic [6:0]   fall_ms;
    logic [2:0]   sel;

    // Code to milliseconds
    function automatic logic [6:0] code_ms(input logic [2:0] code);
        case (code)
            3'h0:    code_ms = DLY_MS_0;
            3'h1:    code_ms = DLY_MS_1;
            3'h2:    code_ms = DLY_MS_2;
            3'h3:    code_ms = DLY_MS_3;
            3'h4:    code_ms = DLY_MS_4;
            3'h5:    code_ms = DLY_MS_5;
            3'h6:    code_ms = DELAY_CODE6_MS;
            default: code_ms = DLY_MS_7;
        endcase
    endfunction

    // Two-flop synchronisers for outside levels
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ctl_s1 <= 6'h00;
            ctl_s2 <= 6'h00;
            pg_s1  <= 10'h000;
            pg_s2  <= 10'h000;
        end else begin
            ctl_s1 <= CTL_PIN;
            ctl_s2 <= ctl_s1;
            pg_s1  <= RAIL_GOOD;
            pg_s2  <= pg_s1;
        end
    end

    // Register writes and read mux
    always_comb begin
        next_mask_a = mask_a;
        next_src_b  = src_b;
        next_delays = delays;
        if (REG_WE) begin
            case (REG_ADDR)
                OFF_GOOD_MASK_A:   next_mask_a = REG_WDATA;
                OFF_SOURCE_MASK_B: next_src_b  = REG_WDATA;
                OFF_EDGE_DELAYS:   next_delays = REG_WDATA;
                default:           next_mask_a = mask_a;     // Unmapped ignored
            endcase
        end
        case (REG_ADDR)
            OFF_GOOD_MASK_A:   next_rdata = mask_a;
            OFF_SOURCE_MASK_B: next_rdata = src_b;
            OFF_EDGE_DELAYS:   next_rdata = delays;
            default:           next_rdata = 8'h00;           // Unmapped reads zero
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            mask_a    <= RST_GOOD_MASK_A;
            src_b     <= RST_SOURCE_MASK_B;
            delays    <= RST_EDGE_DELAYS;
            REG_RDATA <= 8'h00;
        end else begin
            mask_a    <= next_mask_a;
            src_b     <= next_src_b;
            delays    <= next_delays;
            REG_RDATA <= next_rdata;
        end
    end

    // Field decode
    assign sel     = src_b[SEL_LSB +: 3];
    assign rise_ms = code_ms(delays[RISE_LSB +: 3]);
    assign fall_ms = code_ms(delays[FALL_LSB +: 3]);
    assign mask    = {src_b[1:0], mask_a};
    assign tick    = (div == 32'(TICK_LEN - 1));

    // Source multiplexer
    always_comb begin
        case (sel)
            SRC_PIN_ONE:      src_en = ctl_s2[0];
            SRC_PIN_TWO:      src_en = ctl_s2[1];
            SRC_PIN_FIVE:     src_en = ctl_s2[4];
            SRC_PIN_FOUR:     src_en = ctl_s2[3];
            SRC_PIN_THREE:    src_en = ctl_s2[2];
            SRC_PINS_3_AND_4: src_en = ctl_s2[2] & ctl_s2[3];
            SRC_PIN_SIX:      src_en = ctl_s2[5];
            default:          src_en = 1'b1;
        endcase
    end

    // Unmasked good flags gate the request
    assign req = src_en & (&(pg_s2 | mask));

    // Sequencer next state
    always_comb begin
        next_state  = state;
        next_ms_cnt = ms_cnt;
        next_div    = tick ? 32'h0 : div + 32'h1;
        case (state)
            RN_OFF: begin
                next_div    = 32'h0;
                next_ms_cnt = 7'h00;
                if (req) begin
                    next_state = (rise_ms == 7'h00) ? RN_ON : RN_RISE_WAIT;
                end
            end
            RN_RISE_WAIT: begin
                if (!req) begin
                    next_state = RN_OFF;             // Request withdrawn
                end else if (tick) begin
                    next_ms_cnt = ms_cnt + 7'h01;
                    if (ms_cnt + 7'h01 >= rise_ms) begin
                        next_state = RN_ON;
                    end
                end
            end
            RN_ON: begin
                next_div    = 32'h0;
                next_ms_cnt = 7'h00;
                if (!req) begin
                    next_state = (fall_ms == 7'h00) ? RN_OFF : RN_FALL_WAIT;
                end
            end
            RN_FALL_WAIT: begin
                if (req) begin
                    next_state = RN_ON;              // Request returned
                end else if (tick) begin
                    next_ms_cnt = ms_cnt + 7'h01;
                    if (ms_cnt + 7'h01 >= fall_ms) begin
                        next_state = RN_OFF;
                    end
                end
            end
            default: next_state = RN_OFF;
        endcase
        next_enable = (next_state == RN_ON) || (next_state == RN_FALL_WAIT);
    end

    // Sequencer registers
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state       <= RN_OFF;
            div         <= 32'h0;
            ms_cnt      <= 7'h00;
            RAIL_ENABLE <= 1'b0;
        end else begin
            state       <= next_state;
            div         <= next_div;
            ms_cnt      <= next_ms_cnt;
            RAIL_ENABLE <= next_enable;
        end
    end

    // Checks
    sequence fall_start_s;
        state == RN_ON && !req && fall_ms != 7'h00;
    endsequence
    sequence rise_done_s;
        state == RN_RISE_WAIT && req && tick && (ms_cnt + 7'h01 >= rise_ms);
    endsequence

    good_required_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        state == RN_OFF && !pg_s2[0] && !mask[0] |=> !RAIL_ENABLE)
        else $error("enable rose with required rail not good");
    good_ignored_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        state == RN_OFF && mask == 10'h3FF && sel == SRC_ALWAYS_ON && rise_ms == 7'h00
        |=> RAIL_ENABLE)
        else $error("masked good flags still blocked enable");
    mask_write_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        REG_WE && REG_ADDR == OFF_GOOD_MASK_A |=> mask_a == $past(REG_WDATA) ##1
        (REG_RDATA == $past(mask_a) || $past(REG_ADDR) != OFF_GOOD_MASK_A))
        else $error("mask register A write lost");
    mask_b_map_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        state == RN_OFF && !pg_s2[9] && !src_b[1] |=> !RAIL_ENABLE)
        else $error("combined rail good not required");
    pin_pair_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        state == RN_OFF && sel == SRC_PINS_3_AND_4 && !(ctl_s2[2] && ctl_s2[3])
        |=> !RAIL_ENABLE)
        else $error("pin pair source enabled with one pin low");
    rise_delay_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        rise_done_s |=> RAIL_ENABLE && state == RN_ON)
        else $error("rising delay did not end on count");
    fall_delay_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        fall_start_s |=> state == RN_FALL_WAIT && RAIL_ENABLE)
        else $error("falling delay skipped");
    tick_space_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        tick |=> !tick [*8])
        else $error("ms ticks too close together");
    reserved_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        REG_WE && REG_ADDR == OFF_SOURCE_MASK_B
        |=> src_b[7:RSV_B_LSB] == $past(REG_WDATA[7:RSV_B_LSB]))
        else $error("reserved bits not stored");

endmodule
`default_nettype wire

// ===== tb/rnseq_host.sv
// Purpose: Host model driving pins, rail flags and register port
// Assumes: Every change lands on the falling edge
// Notes:   One strobe cycle per write
`timescale 1ns/10ps
`default_nettype none
module rnseq_host (
    input  wire logic       CLK_SYS,
    output logic      [5:0] CTL_PIN,
    output logic      [9:0] RAIL_GOOD,
    output logic      [7:0] REG_ADDR,
    output logic      [7:0] REG_WDATA,
    output logic            REG_WE
);
    // Idle levels from time zero
    initial begin
        CTL_PIN   = 6'h00;
        RAIL_GOOD = 10'h3FF;
        REG_ADDR  = 8'h00;
        REG_WDATA = 8'h00;
        REG_WE    = 1'b0;
    end
    // Single write, strobe held over one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK_SYS);
        REG_ADDR  = a;
        REG_WDATA = d;
        REG_WE    = 1'b1;
        @(negedge CLK_SYS);
        REG_WE    = 1'b0;
        REG_WDATA = ~d;
    endtask
    // Present a read address
    task automatic rd_addr(input logic [7:0] a);
        @(negedge CLK_SYS);
        REG_ADDR = a;
    endtask
    // Set control pins and rail flags
    task automatic pins(input logic [5:0] c, input logic [9:0] g);
        @(negedge CLK_SYS);
        CTL_PIN   = c;
        RAIL_GOOD = g;
    endtask
endmodule
`default_nettype wire

// ===== tb/rnseq_top_tb.sv
// Purpose: Self-checking bench for the converter-four sequencer
// Assumes: Tick shortened to 16 cycles
// Notes:   Expectations queued by the driver, checked by a monitor
`timescale 1ns/10ps
`default_nettype none
module rnseq_top_tb;
    import rnseq_pkg::*;
    localparam int T = 16;
    logic        clk_sys;
    logic        rstn;
    logic [5:0]  ctl_pin;
    logic [9:0]  rail_good;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_we;
    logic [7:0]  reg_rdata;
    logic        rail_enable;
    logic [8:0]  notes [$];
    int          n_errors = 0;
    int          n_compared = 0;
    logic [31:0] seed = 32'h43;
    event        smp;
    logic [5:0]  sel_mask [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
    logic [6:0]  ms_tbl [8] = '{7'h00, 7'h02, 7'h04, 7'h08, 7'h10, 7'h18, 7'h20, 7'h40};
    rnseq_host rnseq_host_i (.CLK_SYS(clk_sys), .CTL_PIN(ctl_pin), .RAIL_GOOD(rail_good),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we));
    rnseq_top #(.TICK_LEN(T), .DELAY_CODE6_MS(7'h20)) rnseq_top_i (.CLK_SYS(clk_sys),
        .RSTN(rstn), .CTL_PIN(ctl_pin), .RAIL_GOOD(rail_good), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RDATA(reg_rdata),
        .RAIL_ENABLE(rail_enable));
    // 125 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Xorshift step
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cmp_byte(input string w, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic cmp_bit(input string w, input logic e, input logic s);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %b seen %b", w, e, s);
        end
    endtask
    // Monitor: oldest note against the settled outputs
    always @(smp) begin
        logic [8:0] n;
        if (notes.size() == 0) begin
            n_errors++;
            $display("Error notes expected one seen none");
        end else begin
            n = notes.pop_front();
            if (n[8]) cmp_byte("REG_RDATA", n[7:0], reg_rdata);
            else cmp_bit("RAIL_ENABLE", n[0], rail_enable);
        end
    end
    // Read with the answer one cycle later
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        rnseq_host_i.rd_addr(a);
        notes.push_back({1'b1, e});
        @(negedge clk_sys);
        -> smp;
    endtask
    // Enable level after a fixed number of cycles
    task automatic chk_en(input int n, input logic e);
        repeat (n) @(negedge clk_sys);
        notes.push_back({8'h00, e});
        -> smp;
    endtask
    task automatic give_verdict;
        $display("Compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        $display("Error run expected end seen running");
        give_verdict;
    end
    // Main sequence
    initial begin
        logic [7:0] r [3];
        logic [5:0] m;
        logic [9:0] k;
        rstn = 1'b0;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        for (int a = 15; a < 20; a++) chk_rd(8'(a), 8'h00);
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            r[i] = seed[7:0];
            rnseq_host_i.wr(8'h10 + 8'(i), r[i]);
        end
        rnseq_host_i.wr(8'h13, seed[15:8]);
        for (int i = 0; i < 3; i++) chk_rd(8'h10 + 8'(i), r[i]);
        chk_rd(8'h13, 8'h00);
        $display("Test registers done");
        rnseq_host_i.wr(8'h10, 8'hFF);
        rnseq_host_i.wr(8'h12, 8'h00);
        for (int c = 0; c < 8; c++) begin
            m = sel_mask[c];
            rnseq_host_i.wr(8'h11, {3'h0, 3'(c), 2'h3});
            rnseq_host_i.pins(m, 10'h3FF);
            chk_en(8, 1'b1);
            rnseq_host_i.pins(~m | (m & (m - 6'h01)), 10'h3FF);
            chk_en(8, 1'(c == 7));
        end
        $display("Test source select done");
        for (int i = 0; i < 10; i++) begin
            k = 10'h001 << i;
            rnseq_host_i.wr(8'h10, 8'h00);
            rnseq_host_i.wr(8'h11, 8'h1C);
            rnseq_host_i.pins(6'h00, ~k);
            chk_en(8, 1'b0);
            rnseq_host_i.wr(8'h10, k[7:0]);
            rnseq_host_i.wr(8'h11, {6'h07, k[9:8]});
            chk_en(8, 1'b1);
        end
        $display("Test masks done");
        rnseq_host_i.wr(8'h10, 8'hFF);
        rnseq_host_i.wr(8'h11, 8'h03);
        rnseq_host_i.pins(6'h00, 10'h3FF);
        for (int c = 0; c < 8; c++) begin
            rnseq_host_i.wr(8'h12, {2'h0, 3'(7 - c), 3'(c)});
            rnseq_host_i.pins(6'h01, 10'h3FF);
            chk_en(ms_tbl[c] * T, 1'b0);
            chk_en(8, 1'b1);
            rnseq_host_i.pins(6'h00, 10'h3FF);
            chk_en(ms_tbl[7 - c] * T, 1'b1);
            chk_en(8, 1'b0);
        end
        rnseq_host_i.wr(8'h12, 8'h07);
        rnseq_host_i.pins(6'h01, 10'h3FF);
        chk_en(500, 1'b0);
        rnseq_host_i.pins(6'h00, 10'h3FF);
        chk_en(600, 1'b0);
        // Request returning inside the fall delay keeps the rail on
        rnseq_host_i.wr(8'h12, 8'h08);
        rnseq_host_i.pins(6'h01, 10'h3FF);
        chk_en(8, 1'b1);
        rnseq_host_i.pins(6'h00, 10'h3FF);
        chk_en(10, 1'b1);
        rnseq_host_i.pins(6'h01, 10'h3FF);
        chk_en(40, 1'b1);
        $display("Test edge delays done");
        give_verdict;
    end
endmodule
`default_nettype wire
